// ==== rtl/bbe_consts.vh ====
// Constants of the byte and bit operation execute unit.
// Included by the execute unit and its operation decoder; definitions only.
`ifndef BBE_CONSTS_VH
`define BBE_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define BBE_OFS_INSTR     8'h00
`define BBE_OFS_ACC       8'h04
`define BBE_OFS_STATUS    8'h08
`define BBE_OFS_FADDR     8'h0c
`define BBE_OFS_FDATA     8'h10
`define BBE_OFS_CYCLES    8'h14

// ----------------------------------------------------------------
// Register selector codes
// ----------------------------------------------------------------
`define BBE_SEL_INSTR     3'h0
`define BBE_SEL_ACC       3'h1
`define BBE_SEL_STATUS    3'h2
`define BBE_SEL_FADDR     3'h3
`define BBE_SEL_FDATA     3'h4
`define BBE_SEL_CYCLES    3'h5
`define BBE_SEL_NONE      3'h7

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define BBE_ST_CARRY      0
`define BBE_ST_HALF       1
`define BBE_ST_ZERO       2
`define BBE_ST_SKIP       3
`define BBE_ST_UNKNOWN    4

// ----------------------------------------------------------------
// Instruction fields and opcodes
// ----------------------------------------------------------------
`define BBE_INSTR_W       14
`define BBE_BYTE_OP_HI    13
`define BBE_BYTE_OP_LO    8
`define BBE_BIT_OP_HI     13
`define BBE_BIT_OP_LO     10
`define BBE_DEST_BIT      7
`define BBE_BITNUM_HI     9
`define BBE_BITNUM_LO     7
`define BBE_FADDR_HI      6
`define BBE_FADDR_LO      0
`define BBE_OP_ADD        6'h07
`define BBE_OP_AND        6'h05
`define BBE_OP_BCLR       4'h4
`define BBE_OP_BSET       4'h5
`define BBE_OP_BTSZ       4'h6
`define BBE_FILE_DEPTH    128

// ----------------------------------------------------------------
// Reset values, responses and timing
// ----------------------------------------------------------------
`define BBE_RST_INSTR     14'h0000
`define BBE_RST_ACC       8'h00
`define BBE_RST_FADDR     7'h00
`define BBE_RST_CYCLES    16'h0000
`define BBE_RESP_OKAY     2'h0
`define BBE_RESP_SLVERR   2'h2
`define BBE_CYC_PER_INSTR 16'h0001

`endif

// ==== rtl/bbe_op_decode.v ====
// Operation decoder and arithmetic for the execute unit.
// Purely combinational; the caller supplies the operand bytes.
`timescale 1ns/1ps
`include "bbe_consts.vh"

module bbe_op_decode
(
	input  wire [13:0] instr,
	input  wire [7:0]  w_val,
	input  wire [7:0]  f_val,
	output reg  [7:0]  result,
	output reg         c_out,
	output reg         hc_out,
	output reg         z_out,
	output reg         wr_w,
	output reg         wr_f,
	output reg         upd_c,
	output reg         upd_hc,
	output reg         upd_z,
	output reg         skip,
	output reg         known
);

	wire [8:0] sum9;
	wire [4:0] nib5;
	wire [7:0] bmask;
	wire [5:0] byte_op;
	wire [3:0] bit_op;
	wire       dest_f;

	assign sum9    = {1'b0, w_val} + {1'b0, f_val};
	assign nib5    = {1'b0, w_val[3:0]} + {1'b0, f_val[3:0]};
	assign byte_op = instr[`BBE_BYTE_OP_HI:`BBE_BYTE_OP_LO];
	assign bit_op  = instr[`BBE_BIT_OP_HI:`BBE_BIT_OP_LO];
	assign dest_f  = instr[`BBE_DEST_BIT];
	assign bmask   = 8'h01 << instr[`BBE_BITNUM_HI:`BBE_BITNUM_LO];

	always @*
	begin
		result = f_val;
		c_out  = 1'b0;
		hc_out = 1'b0;
		z_out  = 1'b0;
		wr_w   = 1'b0;
		wr_f   = 1'b0;
		upd_c  = 1'b0;
		upd_hc = 1'b0;
		upd_z  = 1'b0;
		skip   = 1'b0;
		known  = 1'b1;
		if (byte_op == `BBE_OP_ADD)
		begin
			result = sum9[7:0];
			c_out  = sum9[8];
			hc_out = nib5[4];
			z_out  = (sum9[7:0] == 8'h00);
			upd_c  = 1'b1;
			upd_hc = 1'b1;
			upd_z  = 1'b1;
			wr_w   = ~dest_f;
			wr_f   = dest_f;
		end
		else if (byte_op == `BBE_OP_AND)
		begin
			result = w_val & f_val;
			z_out  = ((w_val & f_val) == 8'h00);
			upd_z  = 1'b1;
			wr_w   = ~dest_f;
			wr_f   = dest_f;
		end
		else if (bit_op == `BBE_OP_BCLR)
		begin
			result = f_val & ~bmask;
			wr_f   = 1'b1;
		end
		else if (bit_op == `BBE_OP_BSET)
		begin
			result = f_val | bmask;
			wr_f   = 1'b1;
		end
		else if (bit_op == `BBE_OP_BTSZ)
		begin
			skip = ((f_val & bmask) == 8'h00);
		end
		else
		begin
			known = 1'b0;
		end
	end

endmodule // bbe_op_decode

// ==== rtl/bbe_exec.v ====
// Byte and bit operation execute unit with an AXI4-Lite register slave.
// Assumes a single clock ref_clk and asynchronous active-low reset nrst.
// Each write to the instruction register is one instruction cycle.
`timescale 1ns/1ps
`include "bbe_consts.vh"

// Overview of operation
// - Opcode 000111 adds accumulator and file register
// - Add updates carry, half carry, zero; one cycle
// - Low seven bits address; bit seven selects destination
// - Opcode 000101 ANDs; only zero flag changes
// - Destination zero writes accumulator, one writes file
// - Prefix 0100 clears selected bit, flags untouched
// - Prefix 0101 sets selected bit, one cycle
// - Bit number zero to seven, address to 127
// - Test zero bit discards next instruction, two cycles
// - Successful test costs second cycle as no-operation
module bbe_exec
(
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ----------------------------------------------------------------
	// Address decoding and byte-lane merge
	// ----------------------------------------------------------------
	function [2:0] reg_sel;
		input [7:0] a;
		begin
			if (a == `BBE_OFS_INSTR)
				reg_sel = `BBE_SEL_INSTR;
			else if (a == `BBE_OFS_ACC)
				reg_sel = `BBE_SEL_ACC;
			else if (a == `BBE_OFS_STATUS)
				reg_sel = `BBE_SEL_STATUS;
			else if (a == `BBE_OFS_FADDR)
				reg_sel = `BBE_SEL_FADDR;
			else if (a == `BBE_OFS_FDATA)
				reg_sel = `BBE_SEL_FDATA;
			else if (a == `BBE_OFS_CYCLES)
				reg_sel = `BBE_SEL_CYCLES;
			else
				reg_sel = `BBE_SEL_NONE;
		end
	endfunction

	function [15:0] lane_merge;
		input [15:0] old_v;
		input [15:0] new_v;
		input [1:0]  strb;
		begin
			lane_merge[7:0]  = strb[0] ? new_v[7:0]  : old_v[7:0];
			lane_merge[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg                        aw_full_q;
	reg  [7:0]                 aw_addr_q;
	reg                        w_full_q;
	reg  [31:0]                w_data_q;
	reg  [3:0]                 w_strb_q;
	reg  [13:0]                instr_q;
	reg  [7:0]                 acc_q;
	reg                        carry_q;
	reg                        half_carry_flag_q;
	reg                        zero_q;
	reg                        skip_q;
	reg                        unknown_q;
	reg  [6:0]                 faddr_q;
	reg  [15:0]                cycles_q;
	reg  [7:0]                 file_mem [0:`BBE_FILE_DEPTH-1];

	wire                       do_write;
	wire [2:0]                 wsel;
	wire [2:0]                 rsel;
	wire                       wr_instr;
	wire                       exec;
	wire [15:0]                instr_m;
	wire [13:0]                instr_d;
	wire [6:0]                 op_addr;
	wire [7:0]                 op_fval;
	wire [7:0]                 res;
	wire                       c_res;
	wire                       hc_res;
	wire                       z_res;
	wire                       wr_w;
	wire                       wr_f;
	wire                       upd_c;
	wire                       upd_hc;
	wire                       upd_z;
	wire                       skip_req;
	wire                       known;
	wire                       mem_we;
	wire [6:0]                 mem_addr;
	wire [7:0]                 mem_data;
	reg  [31:0]                rdata_d;

	assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign wsel     = reg_sel(aw_addr_q);
	assign rsel     = reg_sel(s_axi_araddr);
	assign wr_instr = do_write & (wsel == `BBE_SEL_INSTR);
	assign instr_m  = lane_merge({2'b00, instr_q}, w_data_q[15:0], w_strb_q[1:0]);
	assign instr_d  = instr_m[13:0];
	assign op_addr  = instr_d[`BBE_FADDR_HI:`BBE_FADDR_LO];
	assign op_fval  = file_mem[op_addr];
	assign exec     = wr_instr & ~skip_q;

	// ----------------------------------------------------------------
	// Operation decoder
	// ----------------------------------------------------------------
	bbe_op_decode u_dec
	(
		.instr  (instr_d),
		.w_val  (acc_q),
		.f_val  (op_fval),
		.result (res),
		.c_out  (c_res),
		.hc_out (hc_res),
		.z_out  (z_res),
		.wr_w   (wr_w),
		.wr_f   (wr_f),
		.upd_c  (upd_c),
		.upd_hc (upd_hc),
		.upd_z  (upd_z),
		.skip   (skip_req),
		.known  (known)
	);

	// ----------------------------------------------------------------
	// File register array
	// ----------------------------------------------------------------
	assign mem_we   = (exec & wr_f) | (do_write & (wsel == `BBE_SEL_FDATA) & w_strb_q[0]);
	assign mem_addr = exec ? op_addr : faddr_q;
	assign mem_data = exec ? res : w_data_q[7:0];

	always @(posedge ref_clk)
	begin
		if (mem_we)
			file_mem[mem_addr] <= mem_data;
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channels
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BBE_RESP_OKAY;
			aw_full_q     <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_full_q      <= 1'b0;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wsel == `BBE_SEL_NONE)
					s_axi_bresp <= `BBE_RESP_SLVERR;
				else
					s_axi_bresp <= `BBE_RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Execution and software-written registers
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			instr_q           <= `BBE_RST_INSTR;
			acc_q             <= `BBE_RST_ACC;
			carry_q           <= 1'b0;
			half_carry_flag_q <= 1'b0;
			zero_q            <= 1'b0;
			skip_q            <= 1'b0;
			unknown_q         <= 1'b0;
			faddr_q           <= `BBE_RST_FADDR;
			cycles_q          <= `BBE_RST_CYCLES;
		end
		else if (wr_instr)
		begin
			instr_q  <= instr_d;
			cycles_q <= cycles_q + `BBE_CYC_PER_INSTR;
			if (skip_q)
			begin
				skip_q    <= 1'b0;
				unknown_q <= 1'b0;
			end
			else
			begin
				skip_q    <= skip_req;
				unknown_q <= ~known;
				if (wr_w)
					acc_q <= res;
				if (upd_c)
					carry_q <= c_res;
				if (upd_hc)
					half_carry_flag_q <= hc_res;
				if (upd_z)
					zero_q <= z_res;
			end
		end
		else if (do_write)
		begin
			if (wsel == `BBE_SEL_ACC && w_strb_q[0])
				acc_q <= w_data_q[7:0];
			else if (wsel == `BBE_SEL_STATUS && w_strb_q[0])
			begin
				carry_q           <= w_data_q[`BBE_ST_CARRY];
				half_carry_flag_q <= w_data_q[`BBE_ST_HALF];
				zero_q            <= w_data_q[`BBE_ST_ZERO];
			end
			else if (wsel == `BBE_SEL_FADDR && w_strb_q[0])
				faddr_q <= w_data_q[6:0];
			else if (wsel == `BBE_SEL_CYCLES)
				cycles_q <= `BBE_RST_CYCLES;
		end
	end

	// ----------------------------------------------------------------
	// Read data selection
	// ----------------------------------------------------------------
	always @*
	begin
		rdata_d = 32'h00000000;
		if (rsel == `BBE_SEL_INSTR)
			rdata_d[13:0] = instr_q;
		else if (rsel == `BBE_SEL_ACC)
			rdata_d[7:0] = acc_q;
		else if (rsel == `BBE_SEL_STATUS)
		begin
			rdata_d[`BBE_ST_CARRY]   = carry_q;
			rdata_d[`BBE_ST_HALF]    = half_carry_flag_q;
			rdata_d[`BBE_ST_ZERO]    = zero_q;
			rdata_d[`BBE_ST_SKIP]    = skip_q;
			rdata_d[`BBE_ST_UNKNOWN] = unknown_q;
		end
		else if (rsel == `BBE_SEL_FADDR)
			rdata_d[6:0] = faddr_q;
		else if (rsel == `BBE_SEL_FDATA)
			rdata_d[7:0] = file_mem[faddr_q];
		else if (rsel == `BBE_SEL_CYCLES)
			rdata_d[15:0] = cycles_q;
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channels
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `BBE_RESP_OKAY;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rdata_d;
				if (rsel == `BBE_SEL_NONE)
					s_axi_rresp <= `BBE_RESP_SLVERR;
				else
					s_axi_rresp <= `BBE_RESP_OKAY;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // bbe_exec

// ==== verif/bbe_exec_props.sv ====
// Checker of the execute unit's register bus handshakes.
// Sees only top-level ports; attached by the bind at the foot.
`timescale 1ns/1ps

module bbe_exec_props
(
	input wire        ref_clk,
	input wire        nrst,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	wr_resp_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
	rd_resp_lat_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while pending");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while pending");
	b_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
		else $error("bad write response");
	r_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read not zero");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid && s_axi_arready) else $error("read not closed");

	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h0);
	cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
endmodule // bbe_exec_props

bind bbe_exec bbe_exec_props u_props
(
	.ref_clk(ref_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ==== verif/byte_and_bit_op_execute_bench.sv ====
// Self-checking bench of the execute unit through its register bus.
// Expects the design unit bbe_exec and its constants header.
`timescale 1ns/1ps
`include "bbe_consts.vh"

module byte_and_bit_op_execute_bench;
	reg         ref_clk;
	reg         nrst;
	reg  [7:0]  s_axi_awaddr;
	reg  [7:0]  s_axi_araddr;
	reg  [31:0] s_axi_wdata;
	reg         s_axi_awvalid;
	reg         s_axi_wvalid;
	reg         s_axi_bready;
	reg         s_axi_arvalid;
	reg         s_axi_rready;
	wire        s_axi_awready;
	wire        s_axi_wready;
	wire        s_axi_bvalid;
	wire        s_axi_arready;
	wire        s_axi_rvalid;
	wire [1:0]  s_axi_bresp;
	wire [1:0]  s_axi_rresp;
	wire [31:0] s_axi_rdata;
	integer     n_errors;
	integer     cmp_count;
	integer     i;

	bbe_exec dut
	(
		.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Compare, bus and closing tasks
	// ----------------------------------------------------------------
	task end_of_test;
	begin
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	task chk_data(input [31:0] got, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED t=%0t data %h exp %h", $time, got, exp);
		end
	end
	endtask

	task chk_resp(input [1:0] got, input [1:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED t=%0t resp %h exp %h", $time, got, exp);
		end
	end
	endtask

	task timed_out;
	begin
		n_errors = n_errors + 1;
		$display("CHECK FAILED t=%0t bus wait timed out", $time);
		end_of_test;
	end
	endtask

	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		integer n;
	begin
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n = n + 1;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		if (n >= 50)
			timed_out;
		s_axi_bready <= 1'b0;
		chk_resp(s_axi_bresp, er);
		@(posedge ref_clk);
	end
	endtask

	task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
		integer n;
	begin
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n = n + 1;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		if (n >= 50)
			timed_out;
		s_axi_rready <= 1'b0;
		chk_data(s_axi_rdata, ed);
		chk_resp(s_axi_rresp, er);
		@(posedge ref_clk);
	end
	endtask

	task setf(input [7:0] a, input [31:0] d);
	begin
		wr(`BBE_OFS_FADDR, {24'h0, a}, `BBE_RESP_OKAY);
		wr(`BBE_OFS_FDATA, d, `BBE_RESP_OKAY);
	end
	endtask

	task getf(input [7:0] a, input [31:0] d);
	begin
		wr(`BBE_OFS_FADDR, {24'h0, a}, `BBE_RESP_OKAY);
		rd(`BBE_OFS_FDATA, d, `BBE_RESP_OKAY);
	end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		n_errors = 0;
		cmp_count = 0;
		nrst = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(`BBE_OFS_STATUS, 32'h0, `BBE_RESP_OKAY);
		rd(8'h18, 32'h0, `BBE_RESP_SLVERR);
		wr(8'h18, 32'h5, `BBE_RESP_SLVERR);
		// Add into accumulator, then into file at top address
		wr(`BBE_OFS_ACC, 32'h17, `BBE_RESP_OKAY);
		setf(8'h04, 32'hc2);
		wr(`BBE_OFS_INSTR, 32'h0704, `BBE_RESP_OKAY);
		rd(`BBE_OFS_ACC, 32'hd9, `BBE_RESP_OKAY);
		rd(`BBE_OFS_STATUS, 32'h0, `BBE_RESP_OKAY);
		getf(8'h04, 32'hc2);
		wr(`BBE_OFS_ACC, 32'h88, `BBE_RESP_OKAY);
		setf(8'h7f, 32'h78);
		wr(`BBE_OFS_INSTR, 32'h07ff, `BBE_RESP_OKAY);
		getf(8'h7f, 32'h00);
		rd(`BBE_OFS_ACC, 32'h88, `BBE_RESP_OKAY);
		rd(`BBE_OFS_STATUS, 32'h7, `BBE_RESP_OKAY);
		wr(`BBE_OFS_ACC, 32'h0f, `BBE_RESP_OKAY);
		setf(8'h01, 32'h01);
		wr(`BBE_OFS_INSTR, 32'h0701, `BBE_RESP_OKAY);
		rd(`BBE_OFS_STATUS, 32'h2, `BBE_RESP_OKAY);
		// And keeps carry flags, sets zero only
		wr(`BBE_OFS_STATUS, 32'h3, `BBE_RESP_OKAY);
		wr(`BBE_OFS_ACC, 32'h17, `BBE_RESP_OKAY);
		setf(8'h04, 32'hc2);
		wr(`BBE_OFS_INSTR, 32'h0584, `BBE_RESP_OKAY);
		getf(8'h04, 32'h02);
		rd(`BBE_OFS_STATUS, 32'h3, `BBE_RESP_OKAY);
		wr(`BBE_OFS_ACC, 32'h3d, `BBE_RESP_OKAY);
		wr(`BBE_OFS_INSTR, 32'h0504, `BBE_RESP_OKAY);
		rd(`BBE_OFS_ACC, 32'h00, `BBE_RESP_OKAY);
		rd(`BBE_OFS_STATUS, 32'h7, `BBE_RESP_OKAY);
		// Bit set and clear over every bit position
		wr(`BBE_OFS_STATUS, 32'h5, `BBE_RESP_OKAY);
		for (i = 0; i < 8; i = i + 1)
		begin
			setf(8'h10, 32'h00);
			wr(`BBE_OFS_INSTR, 32'h1410 | (i << 7), `BBE_RESP_OKAY);
			getf(8'h10, 32'h1 << i);
			setf(8'h7f, 32'hff);
			wr(`BBE_OFS_INSTR, 32'h107f | (i << 7), `BBE_RESP_OKAY);
			getf(8'h7f, ~(32'h1 << i) & 32'hff);
		end
		rd(`BBE_OFS_STATUS, 32'h5, `BBE_RESP_OKAY);
		// Bit test: taken skip discards next, not taken runs it
		wr(`BBE_OFS_STATUS, 32'h0, `BBE_RESP_OKAY);
		wr(`BBE_OFS_CYCLES, 32'h0, `BBE_RESP_OKAY);
		wr(`BBE_OFS_ACC, 32'h01, `BBE_RESP_OKAY);
		setf(8'h20, 32'hfe);
		wr(`BBE_OFS_INSTR, 32'h1820, `BBE_RESP_OKAY);
		rd(`BBE_OFS_STATUS, 32'h8, `BBE_RESP_OKAY);
		wr(`BBE_OFS_INSTR, 32'h0720, `BBE_RESP_OKAY);
		rd(`BBE_OFS_ACC, 32'h01, `BBE_RESP_OKAY);
		rd(`BBE_OFS_CYCLES, 32'h2, `BBE_RESP_OKAY);
		rd(`BBE_OFS_STATUS, 32'h0, `BBE_RESP_OKAY);
		wr(`BBE_OFS_INSTR, 32'h18a0, `BBE_RESP_OKAY);
		wr(`BBE_OFS_INSTR, 32'h0720, `BBE_RESP_OKAY);
		rd(`BBE_OFS_ACC, 32'hff, `BBE_RESP_OKAY);
		rd(`BBE_OFS_CYCLES, 32'h4, `BBE_RESP_OKAY);
		// Undecoded word: flagged and counted, nothing else changes
		wr(`BBE_OFS_INSTR, 32'h3000, `BBE_RESP_OKAY);
		rd(`BBE_OFS_STATUS, 32'h10, `BBE_RESP_OKAY);
		rd(`BBE_OFS_ACC, 32'hff, `BBE_RESP_OKAY);
		rd(`BBE_OFS_CYCLES, 32'h5, `BBE_RESP_OKAY);
		end_of_test;
	end
endmodule // byte_and_bit_op_execute_bench
